// ===== logic/pat_mmu.v
/*
 Paged address translation and protection unit: four 64-entry page
 tables, per-level paging control registers, permit and ring checks,
 fault status capture and used/written page tracking.
 Register port map: 00-0F paging control register of level n (1:0 ring,
 2 table_select_bit0, 3 table_select_bit1), 10 fault status (any write
 clears it), 11 control (0 paging enable); other offsets read as zero.
 Page entry: 7:0 physical page, 10:9 ring, 11 used, 12 written, 13 fetch
 permit, 14 read permit, 15 write permit; an entry with no permit at all
 is unmapped and raises page_fault_event instead of protect_violation_event.
 Fault status: 5:0 virtual page, 7:6 table, 8 permit violation, 9 ring
 violation, 10 page fault, 12:11 access type; it keeps the latest fault.
 Assumes one 100 MHz clock, a CPU that keeps one access outstanding
 until its answer (data, write issue or refusal), and memory that
 answers reads with a one-cycle valid pulse. The tables are not reset,
 so software must load them through the shadow window before paging.
*/
// Decided for this implementation: the address-and-strobe port and the address map.
// Function
// - Every 16-bit virtual address outside the open shadow window is turned into an 18-bit physical address.
// - Four page tables of 64 entries sit in on-chip registers so lookup costs no extra cycle.
// - Pages are 1024 words; the 10-bit offset passes through and only the page is remapped.
// - Any virtual page may map to any physical frame without restriction.
// - Each page has separate read, write and fetch permits and a denied type is blocked.
// - Each page entry stores one of four ring numbers.
// - An access to a page whose ring is above the running program's ring is refused.
// - The tables are read and written as 256 words in the window 177400-177777 octal.
// - Each of 16 levels has a paging control register holding its ring and table select.
// - A permit or ring violation captures page and table in status and raises an event.
// - Each entry records whether its page was used and whether it was written.
`timescale 1ns/1ns
`include "pat_consts.vh"

module pat_mmu #(
    parameter N_LEVELS    = 16,
    parameter TBL_ENTRIES = 64
) (
    input  wire        i_clk,
    input  wire        i_resetn,
    input  wire        i_acc_req,
    input  wire [1:0]  i_acc_type,
    input  wire [15:0] i_acc_addr,
    input  wire [15:0] i_acc_wdata,
    input  wire [3:0]  i_level,
    input  wire [15:0] i_mem_rdata,
    input  wire        i_mem_rvalid,
    input  wire [7:0]  i_reg_addr,
    input  wire [15:0] i_reg_wdata,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    output wire        o_mem_req,
    output wire        o_mem_we,
    output wire [17:0] o_mem_addr,
    output wire [15:0] o_mem_wdata,
    output wire [15:0] o_cpu_rdata,
    output wire        o_cpu_rvalid,
    output wire        o_acc_refused,
    output wire        o_protect_violation_event,
    output wire        o_page_fault_event,
    output wire [1:0]  o_cur_ring,
    output wire [15:0] o_reg_rdata
);

    localparam TBL_WORDS = 4 * TBL_ENTRIES;

    function [1:0] pgctl_ring;
        input [3:0] ctl;
        begin
            pgctl_ring = ctl[`PAT_PAGECTL_RING_MSB:`PAT_PAGECTL_RING_LSB];
        end
    endfunction

    function [1:0] pgctl_tsel;
        input [3:0] ctl;
        begin
            pgctl_tsel = {ctl[`PAT_PAGECTL_TSEL1], ctl[`PAT_PAGECTL_TSEL0]};
        end
    endfunction

    // Offsets 00-0F reach the paging control register of level n
    function pgctl_hit;
        input [7:0] ofs;
        begin
            pgctl_hit = (ofs <= `PAT_OFS_PAGECTL_LAST);
        end
    endfunction

    // Shadow window word: bits 7:6 pick the table, 5:0 the entry
    function [7:0] shadow_ofs;
        input [15:0] vaddr;
        begin
            shadow_ofs = vaddr[7:0];
        end
    endfunction

    function permit_of;
        input [15:0] e;
        input [1:0]  t;
        begin
            case (t)
                `PAT_ACC_READ:  permit_of = e[`PAT_ENT_READ_OK];
                `PAT_ACC_WRITE: permit_of = e[`PAT_ENT_WRITE_OK];
                `PAT_ACC_FETCH: permit_of = e[`PAT_ENT_FETCH_OK];
                default:        permit_of = 1'b0;
            endcase
        end
    endfunction

    // Allowed translated access: used always, written only on a write
    function [15:0] mark_entry;
        input [15:0] e;
        input        wr;
        begin
            mark_entry                   = e;
            mark_entry[`PAT_ENT_USED]    = 1'b1;
            mark_entry[`PAT_ENT_WRITTEN] = e[`PAT_ENT_WRITTEN] | wr;
        end
    endfunction

    function [15:0] fault_word;
        input [5:0] page;
        input [1:0] tbl;
        input       perm_bad;
        input       ring_over;
        input       unmapped;
        input [1:0] acc;
        begin
            fault_word = `PAT_ST_RESET;
            fault_word[`PAT_ST_PAGE_MSB:`PAT_ST_PAGE_LSB] = page;
            fault_word[`PAT_ST_TBL_MSB:`PAT_ST_TBL_LSB]   = tbl;
            fault_word[`PAT_ST_PERMIT_VIOL]               = perm_bad;
            fault_word[`PAT_ST_RING_VIOL]                 = ring_over;
            fault_word[`PAT_ST_PAGE_FAULT]                = unmapped;
            fault_word[`PAT_ST_TYPE_MSB:`PAT_ST_TYPE_LSB] = acc;
        end
    endfunction

    // Table storage has no reset; software loads it before paging is on
    reg  [15:0] tbl_mem [0:TBL_WORDS-1];
    reg  [3:0]  pgctl_r [0:N_LEVELS-1];
    reg         paging_en_r;
    reg  [15:0] status_r;
    reg  [15:0] status_nxt;
    reg         rd_pend_r;

    reg         mem_req_r;
    reg         mem_we_r;
    reg  [17:0] mem_addr_r;
    reg  [15:0] mem_wdata_r;
    reg  [15:0] cpu_rdata_r;
    reg         cpu_rvalid_r;
    reg         refused_r;
    reg         pviol_r;
    reg         pfault_r;
    reg  [1:0]  cur_ring_r;
    reg  [15:0] reg_rdata_r;

    integer     i;

    wire [3:0]  cur_pgctl = pgctl_r[i_level];
    wire [1:0]  cur_ring  = pgctl_ring(cur_pgctl);
    wire [1:0]  cur_tsel  = pgctl_tsel(cur_pgctl);
    wire [5:0]  vpage     = i_acc_addr[15:10];
    wire [7:0]  tbl_idx   = {cur_tsel, vpage};
    wire [15:0] ent       = tbl_mem[tbl_idx];
    wire [1:0]  ent_ring  = ent[`PAT_ENT_RING_MSB:`PAT_ENT_RING_LSB];

    // Shadow window is open while paging is off or the program runs on the top ring
    wire        shadow_hit = (i_acc_addr[15:8] == `PAT_SHADOW_HI) &&
                             (!paging_en_r || cur_ring == `PAT_RING_TOP);
    wire        xlate      = paging_en_r && !shadow_hit;

    // No permit at all marks an unmapped page: a page fault, not a violation
    wire        no_map     = !ent[`PAT_ENT_READ_OK] && !ent[`PAT_ENT_WRITE_OK] &&
                             !ent[`PAT_ENT_FETCH_OK];
    wire        permit_ok  = permit_of(ent, i_acc_type);
    wire        ring_bad   = ent_ring > cur_ring;
    wire        permit_bad = !permit_ok && !no_map;
    wire        acc_xl     = i_acc_req && xlate;
    wire        fault_nomap = acc_xl && no_map;
    wire        fault_pv   = acc_xl && !no_map && (permit_bad || ring_bad);
    wire        acc_ok     = i_acc_req && !shadow_hit && !fault_nomap && !fault_pv;

    // Page number replaced, offset kept
    wire [17:0] phys_addr  = xlate ?
                             {ent[`PAT_ENT_PPN_MSB:`PAT_ENT_PPN_LSB], i_acc_addr[9:0]} :
                             {2'h0, i_acc_addr};

    wire        is_write   = i_acc_type == `PAT_ACC_WRITE;
    wire        sh_wr      = i_acc_req && shadow_hit && is_write;
    wire        sh_rd      = i_acc_req && shadow_hit && !is_write;

    // Table write port: shadow writes and usage marking never coincide
    always @(posedge i_clk) begin
        if (sh_wr) begin
            tbl_mem[shadow_ofs(i_acc_addr)] <= i_acc_wdata;
        end else if (acc_ok && xlate) begin
            tbl_mem[tbl_idx] <= mark_entry(ent, is_write);
        end
    end

    // Memory side and CPU answers
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mem_req_r    <= 1'b0;
            mem_we_r     <= 1'b0;
            mem_addr_r   <= 18'h00000;
            mem_wdata_r  <= 16'h0000;
            cpu_rdata_r  <= 16'h0000;
            cpu_rvalid_r <= 1'b0;
            refused_r    <= 1'b0;
            pviol_r      <= 1'b0;
            pfault_r     <= 1'b0;
            rd_pend_r    <= 1'b0;
            cur_ring_r   <= 2'h0;
        end else begin
            mem_req_r    <= acc_ok;
            mem_we_r     <= acc_ok && is_write;
            if (acc_ok) begin
                mem_addr_r  <= phys_addr;
                mem_wdata_r <= i_acc_wdata;
            end
            refused_r    <= fault_nomap || fault_pv;
            pviol_r      <= fault_pv;
            pfault_r     <= fault_nomap;
            cur_ring_r   <= cur_ring;
            // Memory read data only follows an issued read; refused reads never return any
            if (acc_ok && !is_write) begin
                rd_pend_r <= 1'b1;
            end else if (i_mem_rvalid) begin
                rd_pend_r <= 1'b0;
            end
            if (sh_rd) begin
                cpu_rdata_r  <= tbl_mem[shadow_ofs(i_acc_addr)];
                cpu_rvalid_r <= 1'b1;
            end else if (rd_pend_r && i_mem_rvalid) begin
                cpu_rdata_r  <= i_mem_rdata;
                cpu_rvalid_r <= 1'b1;
            end else begin
                cpu_rvalid_r <= 1'b0;
            end
        end
    end

    // Fault status: a capture in the same cycle as a software clear wins
    always @* begin
        status_nxt = status_r;
        if (i_reg_wr && i_reg_addr == `PAT_OFS_STATUS) begin
            status_nxt = `PAT_ST_RESET;
        end
        if (fault_pv || fault_nomap) begin
            status_nxt = fault_word(vpage, cur_tsel, fault_pv && permit_bad,
                                    fault_pv && ring_bad, fault_nomap,
                                    i_acc_type);
        end
    end

    // Register port
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (i = 0; i < N_LEVELS; i = i + 1) begin
                pgctl_r[i] <= `PAT_PAGECTL_RESET;
            end
            paging_en_r <= `PAT_CTRL_RESET;
            status_r    <= `PAT_ST_RESET;
            reg_rdata_r <= 16'h0000;
        end else begin
            status_r <= status_nxt;
            if (i_reg_wr) begin
                if (pgctl_hit(i_reg_addr)) begin
                    pgctl_r[i_reg_addr[3:0]] <= i_reg_wdata[3:0];
                end else if (i_reg_addr == `PAT_OFS_CTRL) begin
                    paging_en_r <= i_reg_wdata[`PAT_CTRL_PAGING_EN];
                end
            end
            if (i_reg_rd) begin
                if (pgctl_hit(i_reg_addr)) begin
                    reg_rdata_r <= {12'h000, pgctl_r[i_reg_addr[3:0]]};
                end else if (i_reg_addr == `PAT_OFS_STATUS) begin
                    reg_rdata_r <= status_r;
                end else if (i_reg_addr == `PAT_OFS_CTRL) begin
                    reg_rdata_r <= {15'h0000, paging_en_r};
                end else begin
                    reg_rdata_r <= 16'h0000;
                end
            end else begin
                reg_rdata_r <= 16'h0000;
            end
        end
    end

    assign o_mem_req                 = mem_req_r;
    assign o_mem_we                  = mem_we_r;
    assign o_mem_addr                = mem_addr_r;
    assign o_mem_wdata               = mem_wdata_r;
    assign o_cpu_rdata               = cpu_rdata_r;
    assign o_cpu_rvalid              = cpu_rvalid_r;
    assign o_acc_refused             = refused_r;
    assign o_protect_violation_event = pviol_r;
    assign o_page_fault_event        = pfault_r;
    assign o_cur_ring                = cur_ring_r;
    assign o_reg_rdata               = reg_rdata_r;

endmodule

// ===== inc/pat_consts.vh
/*
 Constants for the paged address translation and protection unit:
 register offsets, field positions, reset values and encodings.
 Assumes it is included by bare name from the design files.
*/
`ifndef PAT_CONSTS_VH
`define PAT_CONSTS_VH

// Register port offsets (8-bit register address)
`define PAT_OFS_PAGECTL_BASE 8'h00
`define PAT_OFS_PAGECTL_LAST 8'h0F
`define PAT_OFS_STATUS      8'h10
`define PAT_OFS_CTRL        8'h11

// Paging control register fields (one per program level)
`define PAT_PAGECTL_RING_LSB 0
`define PAT_PAGECTL_RING_MSB 1
`define PAT_PAGECTL_TSEL0    2
`define PAT_PAGECTL_TSEL1    3
`define PAT_PAGECTL_RESET    4'h0

// Control register fields
`define PAT_CTRL_PAGING_EN  0
`define PAT_CTRL_RESET      1'h0

// Page table entry fields
`define PAT_ENT_PPN_LSB     0
`define PAT_ENT_PPN_MSB     7
`define PAT_ENT_RING_LSB    9
`define PAT_ENT_RING_MSB    10
`define PAT_ENT_USED        11
`define PAT_ENT_WRITTEN     12
`define PAT_ENT_FETCH_OK    13
`define PAT_ENT_READ_OK     14
`define PAT_ENT_WRITE_OK    15

// Fault status register fields
`define PAT_ST_PAGE_LSB     0
`define PAT_ST_PAGE_MSB     5
`define PAT_ST_TBL_LSB      6
`define PAT_ST_TBL_MSB      7
`define PAT_ST_PERMIT_VIOL  8
`define PAT_ST_RING_VIOL    9
`define PAT_ST_PAGE_FAULT   10
`define PAT_ST_TYPE_LSB     11
`define PAT_ST_TYPE_MSB     12
`define PAT_ST_RESET        16'h0000

// Access types
`define PAT_ACC_READ        2'h0
`define PAT_ACC_WRITE       2'h1
`define PAT_ACC_FETCH       2'h2

// Shadow window 177400..177777 octal: upper address byte
`define PAT_SHADOW_HI       8'hFF
`define PAT_RING_TOP        2'h3

`endif

// ===== sim/pat_mmu_monitor.sv
/*
 Port checker for pat_mmu, bound to the top module.
 Assumes one clock and the active-low asynchronous reset.
*/
`timescale 1ns/1ns
module pat_mmu_monitor (
    input wire        i_clk,
    input wire        i_resetn,
    input wire        i_acc_req,
    input wire [15:0] i_acc_addr,
    input wire        i_mem_rvalid,
    input wire        i_reg_rd,
    input wire        o_mem_req,
    input wire        o_mem_we,
    input wire [17:0] o_mem_addr,
    input wire        o_cpu_rvalid,
    input wire        o_acc_refused,
    input wire        o_protect_violation_event,
    input wire        o_page_fault_event,
    input wire [15:0] o_reg_rdata
);
    default clocking mon_cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    a_refuse_no_mem: assert property (o_acc_refused |-> !o_mem_req)
        else $error("refused access reached memory");
    a_event_refused: assert property ((o_protect_violation_event || o_page_fault_event)
        |-> o_acc_refused)
        else $error("event without refusal");
    a_refuse_caused: assert property (o_acc_refused |-> $past(i_acc_req))
        else $error("refusal without request");
    a_mem_caused: assert property (o_mem_req |-> $past(i_acc_req))
        else $error("memory cycle without request");
    a_write_with_req: assert property (o_mem_we |-> o_mem_req)
        else $error("write strobe without memory cycle");
    a_offset_kept: assert property (o_mem_req
        |-> o_mem_addr[9:0] == $past(i_acc_addr[9:0]))
        else $error("page offset changed");
    a_reg_quiet: assert property (o_reg_rdata != 16'h0000 |-> $past(i_reg_rd))
        else $error("register data outside read answer");
    a_answer_caused: assert property (o_cpu_rvalid
        |-> $past(i_mem_rvalid) || $past(i_acc_req))
        else $error("read answer without cause");
endmodule

bind pat_mmu pat_mmu_monitor pat_mmu_monitor_i (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_acc_req(i_acc_req),
    .i_acc_addr(i_acc_addr), .i_mem_rvalid(i_mem_rvalid), .i_reg_rd(i_reg_rd),
    .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
    .o_cpu_rvalid(o_cpu_rvalid), .o_acc_refused(o_acc_refused),
    .o_protect_violation_event(o_protect_violation_event),
    .o_page_fault_event(o_page_fault_event), .o_reg_rdata(o_reg_rdata));

// ===== sim/pat_mem_model.sv
/*
 Main memory behind the unit: answers each issued read after one or
 four cycles, chosen by i_slow. Assumes one read outstanding.
*/
`timescale 1ns/1ns
module pat_mem_model (
    input  wire        i_clk,
    input  wire        i_resetn,
    input  wire        i_slow,
    input  wire        i_mem_req,
    input  wire        i_mem_we,
    input  wire [17:0] i_mem_addr,
    output reg  [15:0] o_rdata,
    output reg         o_rvalid
);
    reg [2:0]  cnt_r;
    reg [15:0] addr_r;
    // Lines toggle between answers so a stale sample never passes
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_r    <= 3'h0;
            addr_r   <= 16'h0000;
            o_rdata  <= 16'h0000;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= (cnt_r == 3'h1);
            o_rdata  <= (cnt_r == 3'h1) ? (addr_r ^ 16'h5A5A) : ~o_rdata;
            if (i_mem_req && !i_mem_we) begin
                cnt_r  <= i_slow ? 3'h4 : 3'h1;
                addr_r <= i_mem_addr[15:0];
            end else if (cnt_r != 3'h0) begin
                cnt_r <= cnt_r - 3'h1;
            end
        end
    end
endmodule

// ===== sim/pat_mmu_tb.sv
/*
 Bench for pat_mmu: registers, shadow loading, translation, protection.
 Assumes pat_mem_model stands on the memory side.
*/
`timescale 1ns/1ns
`include "pat_consts.vh"
module pat_mmu_tb;
    reg         i_clk = 1'b0, i_resetn = 1'b0, i_acc_req = 1'b0;
    reg  [1:0]  i_acc_type = 2'h0;
    reg  [15:0] i_acc_addr = 16'h0000, i_acc_wdata = 16'h0000, i_reg_wdata = 16'h0000;
    reg  [3:0]  i_level = 4'h0;
    reg  [7:0]  i_reg_addr = 8'h00;
    reg         i_reg_wr = 1'b0, i_reg_rd = 1'b0, slow = 1'b0;
    wire [15:0] i_mem_rdata, o_mem_wdata, o_cpu_rdata, o_reg_rdata;
    wire [17:0] o_mem_addr;
    wire [1:0]  o_cur_ring;
    wire        i_mem_rvalid, o_mem_req, o_mem_we, o_cpu_rvalid, o_acc_refused, pve, pfe;
    logic [15:0] rdata;
    logic        mq, we, rf, pv, fe, rv;
    integer      errors = 0, comparisons = 0, cyc = 0, n;

    pat_mmu pat_mmu_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_acc_req(i_acc_req),
        .i_acc_type(i_acc_type), .i_acc_addr(i_acc_addr), .i_acc_wdata(i_acc_wdata),
        .i_level(i_level), .i_mem_rdata(i_mem_rdata), .i_mem_rvalid(i_mem_rvalid),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_cpu_rdata(o_cpu_rdata),
        .o_cpu_rvalid(o_cpu_rvalid), .o_acc_refused(o_acc_refused),
        .o_protect_violation_event(pve), .o_page_fault_event(pfe),
        .o_cur_ring(o_cur_ring), .o_reg_rdata(o_reg_rdata));
    pat_mem_model pat_mem_model_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_slow(slow),
        .i_mem_req(o_mem_req), .i_mem_we(o_mem_we), .i_mem_addr(o_mem_addr),
        .o_rdata(i_mem_rdata), .o_rvalid(i_mem_rvalid));

    always #5 i_clk = ~i_clk;

    task results;
        begin
            $display("errors %0d comparisons %0d", errors, comparisons);
            if (errors == 0 && comparisons > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            errors = errors + 1;
            results;
        end
    end

    task chk(input logic [39:0] got, input logic [39:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task reg_wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge i_clk);
            i_reg_wr <= 1'b1;
            i_reg_addr <= a;
            i_reg_wdata <= d;
            @(posedge i_clk);
            i_reg_wr <= 1'b0;
        end
    endtask
    task reg_chk(input [7:0] a, input [15:0] e);
        begin
            @(posedge i_clk);
            i_reg_rd <= 1'b1;
            i_reg_addr <= a;
            @(posedge i_clk);
            i_reg_rd <= 1'b0;
            #1 chk(o_reg_rdata, e);
        end
    endtask
    task acc(input [1:0] t, input [15:0] a, input [15:0] d);
        begin
            @(posedge i_clk);
            i_acc_req <= 1'b1;
            i_acc_type <= t;
            i_acc_addr <= a;
            i_acc_wdata <= d;
            @(posedge i_clk);
            i_acc_req <= 1'b0;
            #1 {mq, we, rf, pv, fe, rv} = {o_mem_req, o_mem_we, o_acc_refused, pve, pfe,
                o_cpu_rvalid};
            for (n = 0; n < 20 && mq && !we && !rv; n = n + 1) begin
                @(posedge i_clk);
                #1 rv = o_cpu_rvalid;
            end
            rdata = o_cpu_rdata;
        end
    endtask

    task t_reset_and_off;
        begin
            reg_chk(8'h05, 16'h0000);
            reg_chk(8'h10, 16'h0000);
            reg_chk(8'h20, 16'h0000);
            slow = 1'b1;
            acc(`PAT_ACC_READ, 16'h1234, 16'h0000);
            chk({mq, rv, o_mem_addr}, {2'b11, 18'h01234});
            chk(rdata, 16'h486E);
            slow = 1'b0;
        end
    endtask
    task t_load;
        begin
            acc(`PAT_ACC_WRITE, 16'hFF01, 16'h60A5);
            chk(mq, 1'b0);
            acc(`PAT_ACC_WRITE, 16'hFF02, 16'h0033);
            acc(`PAT_ACC_WRITE, 16'hFF03, 16'hE412);
            acc(`PAT_ACC_WRITE, 16'hFF41, 16'hE63C);
            acc(`PAT_ACC_READ, 16'hFF03, 16'h0000);
            chk({rv, rdata}, {1'b1, 16'hE412});
            reg_wr(8'h00, 16'h0001);
            reg_wr(8'h01, 16'h0007);
            reg_chk(8'h01, 16'h0007);
            reg_wr(8'h11, 16'h0001);
        end
    endtask
    task t_translate;
        begin
            acc(`PAT_ACC_READ, 16'h0555, 16'h0000);
            chk({rv, o_mem_addr, rdata}, {1'b1, 18'h29555, 16'hCF0F});
            acc(`PAT_ACC_FETCH, 16'h0556, 16'h0000);
            chk({mq, rf}, 2'b10);
            @(posedge i_clk);
            i_level <= 4'h1;
            acc(`PAT_ACC_WRITE, 16'h07FF, 16'hBEEF);
            chk({we, o_mem_addr, o_mem_wdata}, {1'b1, 18'h0F3FF, 16'hBEEF});
            chk(o_cur_ring, 2'h3);
            acc(`PAT_ACC_READ, 16'hFF01, 16'h0000);
            chk(rdata, 16'h68A5);
            acc(`PAT_ACC_READ, 16'hFF41, 16'h0000);
            chk(rdata, 16'hFE3C);
        end
    endtask
    task t_protect;
        begin
            @(posedge i_clk);
            i_level <= 4'h0;
            acc(`PAT_ACC_WRITE, 16'h0555, 16'h1111);
            chk({mq, rf, pv}, 3'b011);
            reg_chk(8'h10, 16'h0901);
            acc(`PAT_ACC_FETCH, 16'h0800, 16'h0000);
            chk({mq, rv, rf, fe}, 4'b0011);
            reg_chk(8'h10, 16'h1402);
            reg_wr(8'h10, 16'h0000);
            acc(`PAT_ACC_READ, 16'h0C00, 16'h0000);
            chk({mq, rv, rf, pv}, 4'b0011);
            reg_chk(8'h10, 16'h0203);
        end
    endtask

    initial begin
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_reset_and_off;
        t_load;
        t_translate;
        t_protect;
        results;
    end
endmodule
